// *** src/fmd_pkg.sv ***
package fmd_pkg;

  typedef enum logic [3:0] {
    OP_MUL_HILO          = 4'h0,
    OP_MUL_ACCUMULATE    = 4'h1,
    OP_MUL_SUBTRACT      = 4'h2,
    OP_MUL_TO_GPR        = 4'h3,
    OP_DIVIDE            = 4'h4,
    OP_READ_RESULT_HIGH  = 4'h5,
    OP_READ_RESULT_LOW   = 4'h6,
    OP_WRITE_RESULT_HIGH = 4'h7,
    OP_WRITE_RESULT_LOW  = 4'h8
  } fmd_op_t;

  typedef struct packed {
    fmd_op_t     op;
    logic        isSigned;
    logic [31:0] firstSource;
    logic [31:0] secondSource;
  } fmd_issue_t;

  typedef enum logic [3:0] {
    DV_IDLE  = 4'b0001,
    DV_RSADJ = 4'b0010,
    DV_ITER  = 4'b0100,
    DV_SIGN  = 4'b1000
  } fmd_div_state_t;

  localparam logic [1:0]  MUL_GPR_STALL_NARROW = 2'h1;
  localparam logic [1:0]  MUL_GPR_STALL_WIDE   = 2'h2;
  localparam int          CHUNK_SHIFT          = 16;
  localparam logic [5:0]  DIV_BITS_8           = 6'h08;
  localparam logic [5:0]  DIV_BITS_16          = 6'h10;
  localparam logic [5:0]  DIV_BITS_24          = 6'h18;
  localparam logic [5:0]  DIV_BITS_32          = 6'h20;
  localparam logic [63:0] HILO_RESET           = 64'h0;
  localparam logic [31:0] GPR_DATA_RESET       = 32'h0;

endpackage : fmd_pkg

// *** src/fmd_muldiv_unit.sv ***
// Function
// RL1 - own pipeline, advances despite integer stalls
// RL2 - 32x16 array, one or two passes
// RL3 - width chosen from second source value
// RL4 - narrow every clock, wide every other
// RL5 - non-restoring divide, one bit per clock
// RL6 - early skip; unsigned 9/17/25/33 clocks
// RL7 - divide in progress stalls further issue
// RL8 - sign adjust adds a clock unless positive
// RL9 - wide product stalls dependent follower once
// RL10 - gpr multiply stalls one or two cycles
// RL11 - dependent next instruction adds one stall
// RL12 - gpr multiply result latency two clocks; wide takes three clocks here
// RL13 - accumulate repeat rate one or two
// RL14 - start computing at end of execute
// RL15 - narrow one clock per stage, wide two
// RL16 - products written to hi/lo in writeback
// RL17 - unit may run out of step afterwards
// RL18 - width: second source mult, dividend divide
// RL19 - gpr result arbitrates port, holds pipeline
// RL20 - hi/lo read two, write one clock
`timescale 1ns/1ps
`default_nettype none

module fmd_muldiv_unit (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                issueValid,
  input  wire fmd_pkg::fmd_issue_t issueOp,
  input  wire logic                nextUsesMulResult,
  input  wire logic                gprWrGrant,
  output logic                     intStall,
  output logic                     gprWrReq,
  output logic                     gprValid,
  output logic [31:0]              gprData,
  output logic [31:0]              resultHigh,
  output logic [31:0]              resultLow,
  output logic                     divBusy
);
  import fmd_pkg::*;

  function automatic logic [63:0] partProd(input logic [31:0] a, input logic [15:0] c,
                                           input logic aSigned, input logic cSigned);
    logic signed [32:0] ax;
    logic signed [16:0] cx;
    logic signed [49:0] p;
    ax = {aSigned & a[31], a};
    cx = {cSigned & c[15], c};
    p = ax * cx;
    return {{14{p[49]}}, p};
  endfunction : partProd

  // unit multiply stage and add stage
  logic        mValid, next_mValid;
  fmd_issue_t  mOp, next_mOp;
  logic        mWide, next_mWide;
  logic        mPass, next_mPass;
  logic [63:0] mProd, next_mProd;
  logic        aValid, next_aValid;
  fmd_issue_t  aOp, next_aOp;
  logic [63:0] aProd, next_aProd;
  // result pair and integer return
  logic [63:0] hilo, next_hilo;
  logic        next_gprValid;
  logic [31:0] next_gprData;
  // divider
  fmd_div_state_t divState, next_divState;
  logic [5:0]  divCnt, next_divCnt;
  // one bit above the sign: a divisor with its top bit set doubles past 32 bits
  logic [33:0] divRem, next_divRem;
  logic [31:0] divQuot, next_divQuot;
  logic [31:0] divDsr, next_divDsr;
  logic [31:0] divDvd, next_divDvd;
  logic        divNegQ, next_divNegQ;
  logic        divNegR, next_divNegR;
  // register-targeting stall counter
  logic [1:0]  gprStallCnt, next_gprStallCnt;
  logic        gprExtraOk, next_gprExtraOk;

  logic        issueNarrow, issueIsDiv, accept, mDone, aNeedsPort;
  logic        aHold, aFree, mAdvance, mFree;
  logic [31:0] aGprValue, iterQuot, dvdMag;
  logic [33:0] iterShift, iterRem, remFixed;

  // the second source value, read signed or unsigned, decides the pass count
  assign issueNarrow = issueOp.isSigned ?
                       (issueOp.secondSource[31:15] == {17{issueOp.secondSource[15]}}) :
                       (issueOp.secondSource[31:16] == 16'h0); // RL3 RL18

  assign issueIsDiv = (issueOp.op == OP_DIVIDE);
  assign divBusy    = (divState != DV_IDLE);
  assign mDone      = !mWide || mPass; // RL15
  assign aNeedsPort = aValid && ((aOp.op == OP_MUL_TO_GPR) ||
                                 (aOp.op == OP_READ_RESULT_HIGH) ||
                                 (aOp.op == OP_READ_RESULT_LOW));
  assign aHold      = aNeedsPort && !gprWrGrant; // RL19
  assign aFree      = !aValid || !aHold;
  assign mAdvance   = mValid && mDone && aFree;
  assign mFree      = !mValid || mAdvance;
  assign gprWrReq   = aNeedsPort; // RL19

  // wide first pass keeps the multiply stage busy, so a non-divide follower waits
  always_comb begin
    intStall = 1'b0;
    if (gprStallCnt != 2'h0) begin
      intStall = 1'b1; // RL10 RL11
    end else if (issueValid && divBusy) begin
      intStall = 1'b1; // RL7
    end else if (issueValid && !issueIsDiv && !mFree) begin
      intStall = 1'b1; // RL4 RL9 RL13
    end
  end

  assign accept = issueValid && !intStall; // RL14

  // stall counter for the register-targeting multiply
  always_comb begin
    next_gprStallCnt = gprStallCnt;
    next_gprExtraOk  = gprExtraOk;
    if (accept && (issueOp.op == OP_MUL_TO_GPR)) begin
      next_gprStallCnt = issueNarrow ? MUL_GPR_STALL_NARROW : MUL_GPR_STALL_WIDE; // RL10
      next_gprExtraOk  = 1'b1;
    end else if (gprStallCnt == 2'h1) begin
      if (gprExtraOk && nextUsesMulResult) begin
        next_gprExtraOk = 1'b0; // RL11
      end else begin
        next_gprStallCnt = 2'h0;
        next_gprExtraOk  = 1'b0;
      end
    end else if (gprStallCnt != 2'h0) begin
      next_gprStallCnt = gprStallCnt - 2'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gprStallCnt <= 2'h0;
      gprExtraOk  <= 1'b0;
    end else begin
      gprStallCnt <= next_gprStallCnt;
      gprExtraOk  <= next_gprExtraOk;
    end
  end

  // multiply pipeline; no integer stall input, so it freezes only while a register write waits for the port
  always_comb begin
    next_mValid = mValid;
    next_mOp    = mOp;
    next_mWide  = mWide;
    next_mPass  = mPass;
    next_mProd  = mProd;
    next_aValid = aValid;
    next_aOp    = aOp;
    next_aProd  = aProd;
    if (mValid && !mDone) begin
      next_mPass = 1'b1; // RL2 RL15
      next_mProd = mProd + (partProd(mOp.firstSource, mOp.secondSource[31:16],
                                     mOp.isSigned, mOp.isSigned) << CHUNK_SHIFT); // RL2
    end
    if (aFree) begin
      next_aValid = mAdvance; // RL1 RL17
      if (mAdvance) begin
        next_aOp   = mOp;
        next_aProd = mProd;
      end
    end
    if (mFree) begin
      next_mValid = accept && !issueIsDiv;
      if (accept && !issueIsDiv) begin
        next_mOp   = issueOp;
        next_mWide = !issueNarrow && (issueOp.op <= OP_MUL_TO_GPR);
        next_mPass = 1'b0;
        next_mProd = partProd(issueOp.firstSource, issueOp.secondSource[15:0],
                              issueOp.isSigned, issueOp.isSigned && issueNarrow); // RL2
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mValid <= 1'b0;
      mOp    <= '0;
      mWide  <= 1'b0;
      mPass  <= 1'b0;
      mProd  <= HILO_RESET;
      aValid <= 1'b0;
      aOp    <= '0;
      aProd  <= HILO_RESET;
    end else begin
      mValid <= next_mValid;
      mOp    <= next_mOp;
      mWide  <= next_mWide;
      mPass  <= next_mPass;
      mProd  <= next_mProd;
      aValid <= next_aValid;
      aOp    <= next_aOp;
      aProd  <= next_aProd;
    end
  end

  // divider datapath, positive magnitudes only
  assign dvdMag    = (divDvd[31] && divNegR) ? (32'h0 - divDvd) : divDvd;
  assign iterShift = {divRem[32:0], divQuot[31]};
  assign iterRem   = divRem[33] ? (iterShift + {2'b0, divDsr})
                                : (iterShift - {2'b0, divDsr}); // RL5
  assign iterQuot  = {divQuot[30:0], ~iterRem[33]}; // RL5
  assign remFixed  = iterRem[33] ? (iterRem + {2'b0, divDsr}) : iterRem;

  always_comb begin
    next_divState = divState;
    next_divCnt   = divCnt;
    next_divRem   = divRem;
    next_divQuot  = divQuot;
    next_divDsr   = divDsr;
    next_divDvd   = divDvd;
    next_divNegQ  = divNegQ;
    next_divNegR  = divNegR;
    case (divState)
      DV_IDLE: begin
        if (accept && issueIsDiv) begin
          next_divState = DV_RSADJ;
          next_divDvd   = issueOp.firstSource;
          next_divNegR  = issueOp.isSigned && issueOp.firstSource[31];
          next_divNegQ  = issueOp.isSigned &&
                          (issueOp.firstSource[31] ^ issueOp.secondSource[31]);
          next_divDsr   = (issueOp.isSigned && issueOp.secondSource[31]) ?
                          (32'h0 - issueOp.secondSource) : issueOp.secondSource;
        end
      end
      DV_RSADJ: begin
        // adjust cycle is spent even for a positive dividend
        next_divState = DV_ITER;
        next_divRem   = 34'h0;
        if (dvdMag[31:8] == 24'h0) begin
          next_divCnt  = DIV_BITS_8; // RL6 RL18
          next_divQuot = dvdMag << 24;
        end else if (dvdMag[31:16] == 16'h0) begin
          next_divCnt  = DIV_BITS_16; // RL6
          next_divQuot = dvdMag << 16;
        end else if (dvdMag[31:24] == 8'h0) begin
          next_divCnt  = DIV_BITS_24; // RL6
          next_divQuot = dvdMag << 8;
        end else begin
          next_divCnt  = DIV_BITS_32;
          next_divQuot = dvdMag;
        end
      end
      DV_ITER: begin
        next_divCnt  = divCnt - 6'h1;
        next_divQuot = iterQuot;
        next_divRem  = iterRem;
        if (divCnt == 6'h1) begin
          next_divRem = remFixed;
          // sign stage only when some operand was negative
          next_divState = (divNegQ || divNegR) ? DV_SIGN : DV_IDLE; // RL8
        end
      end
      DV_SIGN: begin
        next_divState = DV_IDLE; // RL8
      end
      default: next_divState = DV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      divState <= DV_IDLE;
      divCnt   <= 6'h0;
      divRem   <= 34'h0;
      divQuot  <= 32'h0;
      divDsr   <= 32'h0;
      divDvd   <= 32'h0;
      divNegQ  <= 1'b0;
      divNegR  <= 1'b0;
    end else begin
      divState <= next_divState;
      divCnt   <= next_divCnt;
      divRem   <= next_divRem;
      divQuot  <= next_divQuot;
      divDsr   <= next_divDsr;
      divDvd   <= next_divDvd;
      divNegQ  <= next_divNegQ;
      divNegR  <= next_divNegR;
    end
  end

  // result pair: add stage result lands on the next edge (writeback)
  always_comb begin
    next_hilo = hilo;
    aGprValue = aProd[31:0];
    if (aValid) begin
      case (aOp.op)
        OP_MUL_HILO:          next_hilo = aProd; // RL16
        OP_MUL_ACCUMULATE:    next_hilo = hilo + aProd; // RL13 RL16
        OP_MUL_SUBTRACT:      next_hilo = hilo - aProd; // RL13 RL16
        OP_WRITE_RESULT_HIGH: next_hilo = {aOp.firstSource, hilo[31:0]}; // RL20
        OP_WRITE_RESULT_LOW:  next_hilo = {hilo[63:32], aOp.firstSource}; // RL20
        OP_READ_RESULT_HIGH:  aGprValue = hilo[63:32]; // RL20
        OP_READ_RESULT_LOW:   aGprValue = hilo[31:0]; // RL20
        default: next_hilo = hilo;
      endcase
    end
    if (divState == DV_ITER && divCnt == 6'h1 && !divNegQ && !divNegR) begin
      next_hilo = {remFixed[31:0], iterQuot}; // RL6 RL8
    end else if (divState == DV_SIGN) begin
      next_hilo = {divNegR ? (32'h0 - divRem[31:0]) : divRem[31:0],
                   divNegQ ? (32'h0 - divQuot) : divQuot}; // RL8
    end
  end

  // integer return is registered once the write port is granted
  always_comb begin
    next_gprValid = aNeedsPort && gprWrGrant; // RL12 RL19
    next_gprData  = gprData;
    if (aNeedsPort && gprWrGrant) begin
      next_gprData = aGprValue; // RL12 RL20
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hilo     <= HILO_RESET;
      gprValid <= 1'b0;
      gprData  <= GPR_DATA_RESET;
    end else begin
      hilo     <= next_hilo;
      gprValid <= next_gprValid;
      gprData  <= next_gprData;
    end
  end

  assign resultHigh = hilo[63:32];
  assign resultLow  = hilo[31:0];

endmodule : fmd_muldiv_unit

`default_nettype wire

// *** test/fmd_int_pipe_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fmd_int_pipe_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       gprWrReq,
  input  wire logic [2:0] portBusy,
  output logic            gprWrGrant
);
  logic [2:0] waited;
  // integer writes hold the port for portBusy cycles of every request
  always_ff @(posedge core_clk) begin
    if (sys_rst || !gprWrReq || gprWrGrant) waited <= 3'h0;
    else waited <= waited + 3'h1;
  end
  assign gprWrGrant = gprWrReq && waited >= portBusy;
endmodule : fmd_int_pipe_model
`default_nettype wire

// *** test/fmd_muldiv_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module fmd_muldiv_asserts (
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic                issueValid,
  input wire fmd_pkg::fmd_issue_t issueOp,
  input wire logic                gprWrGrant,
  input wire logic                intStall,
  input wire logic                gprWrReq,
  input wire logic                gprValid,
  input wire logic                divBusy
);
  import fmd_pkg::*;
  logic        take;
  logic        wide;
  logic [16:0] top;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  assign take = issueValid && !intStall;
  assign top  = issueOp.secondSource[31:15];
  // signed narrow needs bits 31..15 all equal, unsigned needs 31..16 clear
  assign wide = issueOp.isSigned ? !(&top || !(|top)) : |top[16:1];
  wide_interlock_a: assert property (take && wide && issueOp.op < OP_MUL_TO_GPR ##1 issueValid |-> intStall)
    else $error("wide multiply not interlocked");
  narrow_rate_a: assert property (take && !wide && issueOp.op < OP_MUL_TO_GPR |=> !intStall || gprWrReq)
    else $error("narrow multiply blocked next issue");
  gpr_narrow_a: assert property (take && issueOp.op == OP_MUL_TO_GPR |=> !issueValid || intStall)
    else $error("gpr multiply slot stall missing");
  gpr_wide_a: assert property (take && issueOp.op == OP_MUL_TO_GPR && wide |=> (!issueValid || intStall)[*2])
    else $error("wide gpr multiply stall too short");
  div_stall_a: assert property (divBusy && issueValid |-> intStall)
    else $error("issue taken during divide");
  div_run_a: assert property (take && issueOp.op == OP_DIVIDE |=> divBusy[*8])
    else $error("divide ended too early");
  port_hold_a: assert property (gprWrReq && !gprWrGrant |=> gprWrReq)
    else $error("port request dropped before grant");
  gpr_valid_a: assert property (gprValid == $past(gprWrReq && gprWrGrant))
    else $error("gpr write not one cycle after grant");
endmodule : fmd_muldiv_asserts
bind fmd_muldiv_unit fmd_muldiv_asserts u_fmd_muldiv_asserts (
  .core_clk, .sys_rst, .issueValid, .issueOp, .gprWrGrant, .intStall, .gprWrReq, .gprValid,
  .divBusy
);
`default_nettype wire

// *** test/test_fast_multiply_divide_pipeline.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_fast_multiply_divide_pipeline;
  import fmd_pkg::*;
  logic        core_clk = 1'h0, sys_rst = 1'h1, issueValid = 1'h0, nextUsesMulResult = 1'h0;
  logic        intStall, gprWrReq, gprWrGrant, gprValid, divBusy;
  fmd_issue_t  issueOp = '0;
  logic [31:0] gprData, resultHigh, resultLow;
  logic [2:0]  portBusy = 3'h2;
  int          fail_count = 0, num_checks = 0, cyc = 0;

  fmd_muldiv_unit u_fmd_muldiv_unit (
    .core_clk, .sys_rst, .issueValid, .issueOp, .nextUsesMulResult, .gprWrGrant, .intStall,
    .gprWrReq, .gprValid, .gprData, .resultHigh, .resultLow, .divBusy
  );
  fmd_int_pipe_model u_fmd_int_pipe_model (.core_clk, .sys_rst, .gprWrReq, .portBusy, .gprWrGrant);

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      $display("[FAIL] %0t run hung", $time);
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  // holds the request until taken; counts stalled cycles, leaves issueValid up
  task automatic issue(input fmd_op_t op, input logic sg, input logic [31:0] a, b, output int w);
    issueOp = '{op, sg, a, b};
    issueValid = 1'h1;
    w = 0;
    @(negedge core_clk);
    while (intStall !== 1'h0 && w < 60) begin
      w++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    #1;
  endtask : issue

  task automatic gpr_result(input logic [31:0] v);
    int n;
    n = 0;
    while (gprValid !== 1'h1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    check(gprValid === 1'h1 && gprData === v, "gpr write data");
    @(posedge core_clk);
    #1;
  endtask : gpr_result

  task automatic t_mul;
    logic [63:0] e;
    int          w;
    issue(OP_WRITE_RESULT_HIGH, 1'h0, 32'h1, 32'h0, w);
    issue(OP_WRITE_RESULT_LOW, 1'h0, 32'hffff_fff0, 32'h0, w);
    issue(OP_MUL_ACCUMULATE, 1'h0, 32'h1234_5678, 32'h1234, w);
    check(w == 0, "accumulate after hilo write stalled");
    e = 64'h1_ffff_fff0 + 64'h1234_5678 * 64'h1234;
    issue(OP_MUL_SUBTRACT, 1'h1, 32'hffff_fffd, 32'hffff_8000, w);
    check(w == 0, "narrow repeat stalled");
    issue(OP_MUL_HILO, 1'h0, 32'h89ab_cdef, 32'h0001_0000, w);
    check({resultHigh, resultLow} === e, "accumulate result");
    e = e - 64'h1_8000;
    issue(OP_MUL_ACCUMULATE, 1'h0, 32'h2, 32'h3, w);
    check(w == 1, "wide product follower");
    check({resultHigh, resultLow} === e, "signed subtract result");
    issueValid = 1'h0;
    e = 64'h89ab_cdef * 64'h1_0000;
    @(posedge core_clk);
    #1 check({resultHigh, resultLow} === e, "wide product");
    @(posedge core_clk);
    #1 check({resultHigh, resultLow} === e + 64'h6, "accumulate after wide");
  endtask : t_mul

  task automatic t_gpr;
    int w;
    nextUsesMulResult = 1'h1;
    issue(OP_MUL_TO_GPR, 1'h0, 32'h7, 32'h9, w);
    issue(OP_READ_RESULT_LOW, 1'h0, 32'h0, 32'h0, w);
    check(w == 2, "dependent gpr multiply stall");
    issueValid = 1'h0;
    nextUsesMulResult = 1'h0;
    gpr_result(32'h3f);
    gpr_result(32'hcdef_0006);
    issue(OP_MUL_TO_GPR, 1'h0, 32'h3, 32'h0002_0000, w);
    issue(OP_READ_RESULT_HIGH, 1'h0, 32'h0, 32'h0, w);
    check(w == 2, "wide gpr multiply stall");
    issueValid = 1'h0;
    gpr_result(32'h0006_0000);
    gpr_result(32'h0000_89ab);
  endtask : t_gpr

  task automatic t_div;
    logic [31:0] a[7] = '{32'hc8, 32'hc350, 32'hab_cdef, 32'hf000_0000, 32'hffff_ffff,
                          32'hffff_ff9c, 32'hc8};
    logic [31:0] b[7] = '{32'h7, 32'h9, 32'h100, 32'h3, 32'h8000_0001, 32'h7, 32'h7};
    int          lat[7] = '{9, 17, 25, 33, 33, 10, 9};
    logic [31:0] q, r;
    int          n, w;
    for (int i = 0; i < 7; i++) begin
      if (i < 5) begin
        q = a[i] / b[i];
        r = a[i] % b[i];
      end else begin
        q = $signed(a[i]) / $signed(b[i]);
        r = $signed(a[i]) % $signed(b[i]);
      end
      issue(OP_DIVIDE, i >= 5, a[i], b[i], w);
      issueValid = 1'h0;
      n = 0;
      while ({resultHigh, resultLow} !== {r, q} && n < 40) begin
        @(posedge core_clk);
        #1 n++;
      end
      check(n == lat[i], "divide latency");
    end
    issue(OP_DIVIDE, 1'h0, 32'hc8, 32'h7, w);
    issue(OP_MUL_HILO, 1'h0, 32'h5, 32'h6, w);
    check(w >= 8, "issue during divide not held");
    issueValid = 1'h0;
    repeat (2) @(posedge core_clk);
    #1 check({resultHigh, resultLow} === 64'h1e, "product after divide");
  endtask : t_div

  initial begin
    repeat (8) @(posedge core_clk);
    #1 sys_rst = 1'h0;
    check({resultHigh, resultLow, gprValid, gprWrReq, divBusy} === '0, "reset values");
    t_mul();
    t_gpr();
    t_div();
    summarize();
  end
endmodule : test_fast_multiply_divide_pipeline
`default_nettype wire
